//--- core/ect_event_counter_timer.sv
`timescale 1ns/100ps

module ect_event_counter_timer
    import ect_pkg::*;
#(
    parameter int CNT_W = 32
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic exposureBeginEvent,
    input wire logic exposureFinishEvent,
    input wire logic readoutBeginEvent,
    input wire logic readoutFinishEvent,
    input wire logic frameBeginEvent,
    input wire logic acceptedFrameTrigger,
    input wire logic cameraControlLineOne,
    output logic microsecondTick,
    output logic countLimitReachedEvent,
    output logic intervalEndEvent
);

    localparam int NIN = 7;
    localparam int DIV_W = $clog2(US_CYCLES);
    localparam int TICK_GAP = US_CYCLES;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(US_CYCLES - 1);

    typedef struct packed {
        logic [NIN-1:0] sync1;
        logic [NIN-1:0] sync2;
        logic [NIN-1:0] sync3;
        logic [DIV_W-1:0] divCnt;
        logic tick;
        logic addrValid;
        logic addrWrite;
        logic [7:0] addrOff;
        logic [31:0] rdata;
        logic cntMode;
        logic [3:0] cntLaunch;
        logic [3:0] cntClear;
        logic [3:0] cntIncr;
        logic [1:0] cntEdge;
        logic [CNT_W-1:0] cntLimit;
        logic [CNT_W-1:0] cntValue;
        logic [CNT_W-1:0] cntCapt;
        logic cntRun;
        logic cntEnd;
        logic tmrMode;
        logic [3:0] tmrLaunch;
        logic [1:0] tmrEdge;
        logic [CNT_W-1:0] tmrLen;
        logic [CNT_W-1:0] tmrValue;
        ect_tmr_e tmrState;
        logic tmrEnd;
    } ect_state_s;

    ect_state_s state_reg;
    ect_state_s state_next;
    logic [NIN-1:0] rise;
    logic [NIN-1:0] fall;
    logic [NSRC-1:0] cntEvt;
    logic [NSRC-1:0] tmrEvt;
    logic cStart;
    logic cClr;
    logic cInc;
    logic tStart;
    logic wrEn;
    logic cmdCnt;
    logic cmdTmr;
    logic addrTake;
    logic [CNT_W-1:0] cntPlus;
    logic [CNT_W-1:0] tmrPlus;

    // pick the edge the selected activation asks for
    function automatic logic lineEdge(input logic [1:0] sel,
                                      input logic up, input logic down);
        logic hit;
        hit = 1'b0;
        case (sel)
            EDGE_UP: hit = up;
            EDGE_DOWN: hit = down;
            EDGE_EITHER: hit = up | down;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // select one event pulse by source code, unknown codes give none
    function automatic logic pickSrc(input logic [NSRC-1:0] vec,
                                     input logic [3:0] sel);
        logic hit;
        hit = 1'b0;
        if (int'(sel) < NSRC)
        begin
            hit = vec[sel];
        end
        return hit;
    endfunction

    // edges seen on the synchronised inputs
    assign rise = state_reg.sync2 & ~state_reg.sync3;
    assign fall = ~state_reg.sync2 & state_reg.sync3;

    // event vectors indexed by source code
    assign cntEvt = {state_reg.tmrEnd, state_reg.cntEnd, state_reg.tick,
        lineEdge(state_reg.cntEdge, rise[6], fall[6]),
        rise[5:0], 1'b0};
    assign tmrEvt = {state_reg.tmrEnd, state_reg.cntEnd, state_reg.tick,
        lineEdge(state_reg.tmrEdge, rise[6], fall[6]),
        rise[5:0], 1'b0};
    assign cStart = pickSrc(cntEvt, state_reg.cntLaunch);
    assign cClr = pickSrc(cntEvt, state_reg.cntClear);
    assign cInc = pickSrc(cntEvt, state_reg.cntIncr);
    assign tStart = (state_reg.tmrLaunch == SRC_OFF) ? cmdTmr
        : pickSrc(tmrEvt, state_reg.tmrLaunch);
    assign cntPlus = state_reg.cntValue + 1'b1;
    assign tmrPlus = state_reg.tmrValue + 1'b1;

    // bus data phase decode; the slave never inserts wait states
    assign wrEn = state_reg.addrValid & state_reg.addrWrite;
    assign cmdCnt = wrEn & (state_reg.addrOff == OFF_COMMAND)
        & hwdata[CMD_CNT_BIT];
    assign cmdTmr = wrEn & (state_reg.addrOff == OFF_COMMAND)
        & hwdata[CMD_TMR_BIT];
    assign addrTake = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = state_reg.rdata;
    assign microsecondTick = state_reg.tick;
    assign countLimitReachedEvent = state_reg.cntEnd;
    assign intervalEndEvent = state_reg.tmrEnd;

    // next state of the whole block
    always_comb
    begin
        state_next = state_reg;
        // input synchroniser chain and microsecond divider
        state_next.sync1 = {cameraControlLineOne, acceptedFrameTrigger,
            frameBeginEvent, readoutFinishEvent, readoutBeginEvent,
            exposureFinishEvent, exposureBeginEvent};
        state_next.sync2 = state_reg.sync1;
        state_next.sync3 = state_reg.sync2;
        state_next.tick = 1'b0;
        if (state_reg.divCnt == DIV_LAST)
        begin
            state_next.divCnt = '0;
            state_next.tick = 1'b1;
        end
        else
        begin
            state_next.divCnt = state_reg.divCnt + 1'b1;
        end

        // register writes in the data phase
        if (wrEn)
        begin
            case (state_reg.addrOff)
                OFF_CNT_CFG:
                begin
                    state_next.cntMode = hwdata[CFG_MODE_BIT];
                    state_next.cntLaunch = hwdata[CFG_LAUNCH_LSB +: 4];
                    state_next.cntClear = hwdata[CFG_CLEAR_LSB +: 4];
                    state_next.cntIncr = hwdata[CFG_INCR_LSB +: 4];
                    state_next.cntEdge = hwdata[CFG_EDGE_LSB +: 2];
                end
                OFF_CNT_LIMIT: state_next.cntLimit = CNT_W'(hwdata);
                OFF_TMR_CFG:
                begin
                    state_next.tmrMode = hwdata[CFG_MODE_BIT];
                    if (!state_reg.tmrMode)
                    begin
                        state_next.tmrLaunch = hwdata[CFG_LAUNCH_LSB +: 4];
                        state_next.tmrEdge = hwdata[CFG_EDGE_LSB +: 2];
                    end
                end
                OFF_TMR_LEN:
                begin
                    if (!state_reg.tmrMode)
                    begin
                        state_next.tmrLen = CNT_W'(hwdata);
                    end
                end
                default: ;
            endcase
        end

        // event counter
        state_next.cntEnd = 1'b0;
        if (!state_reg.cntMode)
        begin
            state_next.cntRun = 1'b0;
        end
        else if (cmdCnt)
        begin
            state_next.cntCapt = state_reg.cntValue;
            state_next.cntValue = '0;
            state_next.cntRun = 1'b1;
        end
        else
        begin
            if (!state_reg.cntRun && state_reg.cntLaunch == SRC_CNT_END)
            begin
                state_next.cntRun = 1'b1;
            end
            else if (!state_reg.cntRun && state_reg.cntLaunch != SRC_OFF
                && cStart)
            begin
                state_next.cntRun = 1'b1;
            end
            if (state_reg.cntRun && cInc)
            begin
                state_next.cntValue = cntPlus;
                if (cntPlus == state_reg.cntLimit)
                begin
                    state_next.cntEnd = 1'b1;
                    // a self launched counter never stops on its end
                    if (state_reg.cntClear != SRC_CNT_END
                        && state_reg.cntLaunch != SRC_CNT_END)
                    begin
                        state_next.cntRun = 1'b0; // failsafe stop
                    end
                end
            end
            if (cClr)
            begin
                // capture the count held before the clear
                state_next.cntCapt = state_reg.cntValue;
                state_next.cntValue = '0;
                state_next.cntRun = state_reg.cntLaunch == SRC_CNT_END;
            end
        end

        // interval unit, counting microsecond ticks up to its length
        state_next.tmrEnd = 1'b0;
        if (!state_reg.tmrMode)
        begin
            state_next.tmrState = TMR_IDLE;
            state_next.tmrValue = '0;
        end
        else
        begin
            unique case (state_reg.tmrState)
                TMR_IDLE:
                begin
                    if (state_reg.tmrLaunch != SRC_OFF)
                    begin
                        state_next.tmrState = TMR_WAITING;
                    end
                    else if (cmdTmr)
                    begin
                        state_next.tmrState = TMR_RUNNING;
                        state_next.tmrValue = '0;
                    end
                end
                TMR_WAITING:
                begin
                    if (tStart)
                    begin
                        state_next.tmrState = TMR_RUNNING;
                        state_next.tmrValue = '0;
                    end
                end
                TMR_RUNNING:
                begin
                    if (cmdTmr)
                    begin
                        state_next.tmrValue = '0;
                        if (state_reg.tmrLaunch != SRC_OFF)
                        begin
                            state_next.tmrState = TMR_WAITING;
                        end
                    end
                    else if (state_reg.tick)
                    begin
                        state_next.tmrValue = tmrPlus;
                        if (tmrPlus >= state_reg.tmrLen)
                        begin
                            state_next.tmrState = TMR_DONE;
                            state_next.tmrEnd = 1'b1;
                        end
                    end
                end
                TMR_DONE:
                begin
                    if (tStart)
                    begin
                        state_next.tmrState = TMR_RUNNING;
                        state_next.tmrValue = '0;
                    end
                end
            endcase
        end

        // address phase capture and read data for the next data phase
        state_next.addrValid = addrTake;
        state_next.addrWrite = hwrite;
        state_next.addrOff = haddr[7:0];
        if (addrTake && !hwrite)
        begin
            case (haddr[7:0])
                OFF_CNT_CFG: state_next.rdata = 32'({state_reg.cntEdge,
                    state_reg.cntIncr, state_reg.cntClear,
                    state_reg.cntLaunch, 3'h0, state_reg.cntMode});
                OFF_CNT_LIMIT: state_next.rdata = 32'(state_reg.cntLimit);
                OFF_CNT_LIVE:
                    state_next.rdata = 32'(state_reg.cntValue);
                OFF_CNT_CAPT: state_next.rdata = 32'(state_reg.cntCapt);
                OFF_TMR_CFG: state_next.rdata = 32'({state_reg.tmrEdge,
                    8'h00, state_reg.tmrLaunch, 3'h0, state_reg.tmrMode});
                OFF_TMR_LEN: state_next.rdata = 32'(state_reg.tmrLen);
                OFF_TMR_ELAPSED:
                    state_next.rdata = 32'(state_reg.tmrValue);
                OFF_TMR_STATE: state_next.rdata = 32'(state_reg.tmrState);
                default: state_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= '0;
            state_reg.cntLimit <= CNT_W'(CNT_LIMIT_RST);
            state_reg.tmrLen <= CNT_W'(TMR_LEN_RST);
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    cmd_capture_a: assert property (state_reg.cntMode
        && cmdCnt |=> state_reg.cntValue == '0 && state_reg.cntRun
        && state_reg.cntCapt == $past(state_reg.cntValue))
        else $error("clear command did not capture and restart");
    incr_off_a: assert property (state_reg.cntIncr == SRC_OFF
        && !cmdCnt && !cClr |=> $stable(state_reg.cntValue))
        else $error("counter moved with increment source off");
    self_start_a: assert property (state_reg.cntMode
        && state_reg.cntLaunch == SRC_CNT_END && !cmdCnt && !cClr
        |=> state_reg.cntRun)
        else $error("self launched counter not running");
    cnt_end_a: assert property (state_reg.cntMode
        && state_reg.cntRun && cInc && !cmdCnt
        && cntPlus == state_reg.cntLimit
        |=> countLimitReachedEvent ##1 !countLimitReachedEvent)
        else $error("counter end pulse missing");
    tick_gap_a: assert property (microsecondTick
        |=> !microsecondTick ##(TICK_GAP - 1) microsecondTick)
        else $error("microsecond tick period wrong");
    tmr_lock_a: assert property (state_reg.tmrMode
        && $past(state_reg.tmrMode) |-> $stable(state_reg.tmrLen)
        && $stable(state_reg.tmrLaunch))
        else $error("timer configuration changed while enabled");
    tmr_done_a: assert property (state_reg.tmrMode
        && state_reg.tmrState == TMR_RUNNING && state_reg.tick && !cmdTmr
        && tmrPlus >= state_reg.tmrLen
        |=> state_reg.tmrState == TMR_DONE && intervalEndEvent)
        else $error("timer did not complete at its length");
    tmr_clear_a: assert property (state_reg.tmrMode
        && state_reg.tmrState == TMR_RUNNING && cmdTmr
        && state_reg.tmrLaunch != SRC_OFF
        |=> state_reg.tmrState == TMR_WAITING && state_reg.tmrValue == '0)
        else $error("timer clear did not rewait");
    read_live_a: assert property (addrTake && !hwrite
        && haddr[7:0] == OFF_CNT_LIVE
        |=> hrdata == 32'($past(state_reg.cntValue)))
        else $error("live count read mismatch");

    cnt_wrap_c: cover property (countLimitReachedEvent
        && state_reg.cntClear == SRC_CNT_END);
    tmr_done_c: cover property (state_reg.tmrState == TMR_RUNNING
        ##1 state_reg.tmrState == TMR_DONE);
    line_launch_c: cover property (state_reg.tmrLaunch == SRC_LINE
        && state_reg.tmrState == TMR_WAITING && tStart);

endmodule

//--- core/ect_pkg.sv
package ect_pkg;

    // clock and microsecond tick timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int US_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] OFF_CNT_CFG = 8'h00;
    localparam logic [7:0] OFF_CNT_LIMIT = 8'h04;
    localparam logic [7:0] OFF_COMMAND = 8'h08;
    localparam logic [7:0] OFF_CNT_LIVE = 8'h0c;
    localparam logic [7:0] OFF_CNT_CAPT = 8'h10;
    localparam logic [7:0] OFF_TMR_CFG = 8'h14;
    localparam logic [7:0] OFF_TMR_LEN = 8'h18;
    localparam logic [7:0] OFF_TMR_ELAPSED = 8'h1c;
    localparam logic [7:0] OFF_TMR_STATE = 8'h20;

    // field positions in the configuration and command words
    localparam int CFG_MODE_BIT = 0;
    localparam int CFG_LAUNCH_LSB = 4;
    localparam int CFG_CLEAR_LSB = 8;
    localparam int CFG_INCR_LSB = 12;
    localparam int CFG_EDGE_LSB = 16;
    localparam int CFG_UNIT_LSB = 20;
    localparam int CMD_CNT_BIT = 0;
    localparam int CMD_TMR_BIT = 1;

    // source codes shared by launch, clear and increment selects
    localparam logic [3:0] SRC_OFF = 4'h0;
    localparam logic [3:0] SRC_EXP_BEGIN = 4'h1;
    localparam logic [3:0] SRC_EXP_FINISH = 4'h2;
    localparam logic [3:0] SRC_RD_BEGIN = 4'h3;
    localparam logic [3:0] SRC_RD_FINISH = 4'h4;
    localparam logic [3:0] SRC_FRAME_BEGIN = 4'h5;
    localparam logic [3:0] SRC_ACC_TRIGGER = 4'h6;
    localparam logic [3:0] SRC_LINE = 4'h7;
    localparam logic [3:0] SRC_TICK = 4'h8;
    localparam logic [3:0] SRC_CNT_END = 4'h9;
    localparam logic [3:0] SRC_TMR_END = 4'ha;
    localparam int NSRC = 11;

    // line edge codes
    localparam logic [1:0] EDGE_UP = 2'h0;
    localparam logic [1:0] EDGE_DOWN = 2'h1;
    localparam logic [1:0] EDGE_EITHER = 2'h2;

    // reset values
    localparam logic [31:0] CNT_LIMIT_RST = 32'hffff_ffff;
    localparam logic [31:0] TMR_LEN_RST = 32'h0000_0001;

    // interval unit states
    typedef enum logic [1:0] {
        TMR_IDLE,
        TMR_WAITING,
        TMR_RUNNING,
        TMR_DONE
    } ect_tmr_e;

endpackage

//--- testbench/ect_event_counter_timer_bench.sv
`timescale 1ns/100ps
module ect_event_counter_timer_bench
    import ect_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic microsecondTick;
    logic countLimitReachedEvent;
    logic intervalEndEvent;
    logic [5:0] evt = 6'h00;
    logic ccLine = 1'b0;
    logic rdPhase = 1'b0;
    logic [31:0] expQ[$];
    logic [3:0] srcs [8] = '{SRC_EXP_BEGIN, SRC_EXP_FINISH, SRC_RD_BEGIN,
        SRC_RD_FINISH, SRC_FRAME_BEGIN, SRC_ACC_TRIGGER, SRC_LINE,
        SRC_CNT_END};
    int miscompares = 0;
    int testsRun = 0;
    int endCount = 0;
    int tickGap = 0;
    int seed = 32'h3733;
    int n;
    int cyc;

    // free-running 100 MHz clock
    always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

    ect_event_counter_timer uut (
        .sys_clk(sys_clk),
        .reset(reset),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .exposureBeginEvent(evt[0]),
        .exposureFinishEvent(evt[1]),
        .readoutBeginEvent(evt[2]),
        .readoutFinishEvent(evt[3]),
        .frameBeginEvent(evt[4]),
        .acceptedFrameTrigger(evt[5]),
        .cameraControlLineOne(ccLine),
        .microsecondTick(microsecondTick),
        .countLimitReachedEvent(countLimitReachedEvent),
        .intervalEndEvent(intervalEndEvent)
    );

    // verdict and end of run
    task stopTest();
        $display("compares %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one single AHB-Lite transfer, held until hready is seen high
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    // the note goes in before the transfer, the watcher pops it
    task rd(input logic [7:0] a, input logic [31:0] exp);
        expQ.push_back(exp);
        bus(1'b0, a, ~exp);
    endtask

    // index below 6 pulses a camera event, 6 toggles the control line
    task pulse(input int idx);
        @(posedge sys_clk);
        if (idx < 6)
            evt[idx] <= 1'b1;
        else
            ccLine <= ~ccLine;
        repeat (3) @(posedge sys_clk);
        if (idx < 6)
            evt[idx] <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    function automatic logic [31:0] cfg(input logic m, input logic [3:0] ln,
        input logic [3:0] cl, input logic [3:0] inc, input logic [1:0] ed);
        return 32'(m) | (32'(ln) << CFG_LAUNCH_LSB) |
            (32'(cl) << CFG_CLEAR_LSB) | (32'(inc) << CFG_INCR_LSB) |
            (32'(ed) << CFG_EDGE_LSB);
    endfunction

    // watcher: read data, response, tick spacing, counter end pulses
    always @(posedge sys_clk)
    begin
        if (rdPhase === 1'b1)
        begin
            cmp(hrdata, expQ.pop_front());
            cmp({31'h0, hresp}, 32'h0);
            cmp({31'h0, hreadyout}, 32'h1);
        end
        if (microsecondTick === 1'b1)
        begin
            if (tickGap > 0)
                cmp(32'(tickGap), 32'(US_CYCLES));
            tickGap = 1;
        end
        else if (tickGap > 0)
            tickGap++;
        if (countLimitReachedEvent === 1'b1)
            endCount++;
        rdPhase <= hsel & htrans[1] & ~hwrite & hreadyout;
    end

    // hang guard
    initial
    begin
        #(CLK_PERIOD_NS * 30000);
        miscompares++;
        stopTest();
    end

    // main sequence
    initial
    begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        wr(8'h24, 32'hffff_ffff);
        rd(8'h24, 32'h0);
        rd(OFF_CNT_CFG, 32'h0);
        rd(OFF_CNT_LIMIT, CNT_LIMIT_RST);
        rd(OFF_TMR_LEN, TMR_LEN_RST);
        rd(OFF_TMR_STATE, 32'(TMR_IDLE));
        rd(OFF_COMMAND, 32'h0);
        // periodic self-launching counter
        wr(OFF_CNT_LIMIT, 32'h3);
        wr(OFF_CNT_CFG, cfg(1, SRC_CNT_END, SRC_CNT_END, SRC_EXP_BEGIN, 0));
        repeat (4) pulse(0);
        rd(OFF_CNT_LIVE, 32'h1);
        rd(OFF_CNT_CAPT, 32'h3);
        cmp(32'(endCount), 32'h1);
        wr(OFF_COMMAND, 32'h1);
        repeat (2) pulse(0);
        rd(OFF_CNT_LIVE, 32'h2);
        // command-started counter, stopped by its clear event
        n = 1 + ($unsigned($random(seed)) % 8);
        wr(OFF_CNT_LIMIT, 32'h40);
        wr(OFF_CNT_CFG, cfg(1, SRC_OFF, SRC_EXP_FINISH, SRC_EXP_BEGIN, 0));
        wr(OFF_COMMAND, 32'h1);
        repeat (n) pulse(0);
        rd(OFF_CNT_LIVE, 32'(n));
        pulse(1);
        repeat (2) pulse(0);
        rd(OFF_CNT_LIVE, 32'h0);
        rd(OFF_CNT_CAPT, 32'(n));
        wr(OFF_COMMAND, 32'h1);
        repeat (3) pulse(0);
        rd(OFF_CNT_LIVE, 32'h3);
        rd(OFF_CNT_CAPT, 32'h0);
        wr(OFF_CNT_CFG, cfg(1, SRC_OFF, SRC_EXP_FINISH, SRC_OFF, 0));
        pulse(0);
        rd(OFF_CNT_LIVE, 32'h3);
        // line counting for each edge mode
        for (int e = 0; e < 3; e++)
        begin
            wr(OFF_CNT_CFG, cfg(1, SRC_OFF, SRC_OFF, SRC_LINE, 2'(e)));
            wr(OFF_COMMAND, 32'h1);
            repeat (4) pulse(6);
            rd(OFF_CNT_LIVE, (e == 2) ? 32'h4 : 32'h2);
        end
        // elapsed ticks between exposure begin and finish; the window
        // from launch edge to clear edge is n tick periods plus one clock cycle
        wr(OFF_CNT_LIMIT, 32'hffff_ffff);
        wr(OFF_CNT_CFG, cfg(1, SRC_OFF, SRC_EXP_FINISH, SRC_OFF, 0));
        pulse(1);
        wr(OFF_CNT_CFG, cfg(1, SRC_EXP_BEGIN, SRC_EXP_FINISH, SRC_TICK, 0));
        pulse(0);
        repeat (US_CYCLES * n - 6) @(posedge sys_clk);
        pulse(1);
        rd(OFF_CNT_CAPT, 32'(n));
        // counter ends on every exposure begin, feeding the timer launch
        wr(OFF_CNT_LIMIT, 32'h1);
        wr(OFF_CNT_CFG, cfg(1, SRC_CNT_END, SRC_CNT_END, SRC_EXP_BEGIN, 0));
        wr(OFF_COMMAND, 32'h1);
        wr(OFF_TMR_LEN, 32'h3);
        for (int k = 0; k < 8; k++)
        begin
            wr(OFF_TMR_CFG, cfg(0, srcs[k], 0, 0, EDGE_DOWN));
            wr(OFF_TMR_CFG, cfg(1, srcs[k], 0, 0, EDGE_DOWN));
            rd(OFF_TMR_STATE, 32'(TMR_WAITING));
            if (k == 6)
            begin
                pulse(6);
                rd(OFF_TMR_STATE, 32'(TMR_WAITING));
            end
            pulse((k == 7) ? 0 : k);
            rd(OFF_TMR_STATE, 32'(TMR_RUNNING));
        end
        // locked configuration, clear while running, full run
        wr(OFF_TMR_LEN, 32'h7);
        rd(OFF_TMR_LEN, 32'h3);
        wr(OFF_COMMAND, 32'h2);
        rd(OFF_TMR_STATE, 32'(TMR_WAITING));
        rd(OFF_TMR_ELAPSED, 32'h0);
        pulse(0);
        cyc = 6;
        while (intervalEndEvent !== 1'b1 && cyc < 600)
        begin
            @(posedge sys_clk);
            cyc++;
        end
        cyc = int'(cyc >= 2 * US_CYCLES && cyc <= 3 * US_CYCLES + 20);
        cmp(32'(cyc), 32'h1);
        rd(OFF_TMR_STATE, 32'(TMR_DONE));
        // launch off: the clear command starts the timer
        wr(OFF_TMR_CFG, cfg(0, SRC_OFF, 0, 0, EDGE_UP));
        wr(OFF_TMR_CFG, cfg(1, SRC_OFF, 0, 0, EDGE_UP));
        rd(OFF_TMR_STATE, 32'(TMR_IDLE));
        wr(OFF_COMMAND, 32'h2);
        rd(OFF_TMR_STATE, 32'(TMR_RUNNING));
        stopTest();
    end
endmodule
